// ---- bus_ctl_model.sv ----
// Two-wire bus controller model facing the wiper target
`timescale 1ns/100ps
module bus_ctl_model (
  // Clock
  input wire logic clk,
  // Bus lines
  input wire logic sda,
  output logic scl,
  output logic sda_rel
);
  logic ph = 1'b0;
  initial begin
    scl = 1'b1;
    sda_rel = 1'b1;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask : wt
  // Start: data falls while clock high, also usable as repeated start
  task automatic start();
    wt(2);
    sda_rel <= 1'b1;
    wt(4);
    scl <= 1'b1;
    wt(6);
    sda_rel <= 1'b0;
    wt(6);
    scl <= 1'b0;
  endtask : start
  task automatic bit_io(input logic b, output logic r);
    wt(2);
    sda_rel <= b;
    wt(4);
    scl <= 1'b1;
    // Uneven high halves keep the mean period at 125 ns
    wt(6 + int'(ph));
    ph = ~ph;
    r = sda;
    scl <= 1'b0;
  endtask : bit_io
  task automatic xfer(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx, output logic ack);
    for (int i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);
    bit_io(ack_in, ack);
  endtask : xfer
  task automatic stop();
    wt(2);
    sda_rel <= 1'b0;
    wt(4);
    scl <= 1'b1;
    wt(6);
    sda_rel <= 1'b1;
    wt(6);
  endtask : stop
endmodule : bus_ctl_model

// ---- dual_wiper_i2c_target.sv ----
// Two-wire serial target for a dual 256-step wiper
// Notes on behaviour
// RL1 - Controller opens each transfer with start
// RL2 - First byte: address plus direction bit
// RL3 - Matching address acknowledged on ninth pulse
// RL4 - Non-matching device stays released and idle
// RL5 - Direction one reads, zero writes
// RL6 - Instruction MSB picks channel one or two
// RL7 - Next bit is shutdown control
// RL8 - Shutdown keeps code; release reapplies it
// RL9 - Codes still accepted during shutdown
// RL10 - Low six instruction bits ignored
// RL11 - Data byte plus acknowledge, nine pulses
// RL12 - Data changes only while clock low
// RL13 - Read sends code right after address
// RL14 - Read returns last selected channel code
// RL15 - Instruction alone latches channel select
// RL16 - Controller closes transfer with stop
// RL17 - Write stop formed on tenth pulse
// RL18 - Read ends with not-acknowledge then stop
// RL19 - Each further write byte updates wiper
// RL20 - New instruction needs new transfer
// RL21 - Repeated reads resend the selected code
// RL22 - Both wipers preset to midscale
// RL23 - Address parameter, low bits from pins
// RL24 - Own wiper registers, shutdown, select flags
`timescale 1ns/100ps
module dual_wiper_i2c_target #(
  parameter logic [6:0] DEV_ADDR = wiper_pkg::DEV_ADDR_DEFAULT,
  parameter bit USE_ADDR_PINS = 1'b1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Serial bus pins
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  // Address pins
  input wire logic addr_pin_low,
  input wire logic addr_pin_high,
  // Ladder control
  output logic [7:0] wiper_register_1,
  output logic [7:0] wiper_register_2,
  output logic [7:0] ladder_code_1,
  output logic [7:0] ladder_code_2,
  output logic shutdown_bit,
  output logic channel_select_bit
);
  typedef enum logic [5:0] {
    ST_IDLE = 6'b000001,
    ST_ADDR = 6'b000010,
    ST_INSTR = 6'b000100,
    ST_WDATA = 6'b001000,
    ST_RDATA = 6'b010000,
    ST_IGNORE = 6'b100000
  } phase_t;

  typedef struct packed {
    phase_t phase;
    logic [3:0] bit_cnt;
    logic [7:0] shreg;
    logic [7:0] tx;
    logic ack_drv;
    logic tx_drv;
    logic in_ack;
    logic rd_nack;
    logic scl_d;
    logic sda_d;
    logic [7:0] wiper1;
    logic [7:0] wiper2;
    logic shdn;
    logic chsel;
    logic [1:0] pins;
    logic ack_due;
    logic wait_rise;
  } tgt_state_t;

  tgt_state_t st_r;
  tgt_state_t st_nxt;
  logic scl_s;
  logic sda_s;
  logic pin_lo_s;
  logic pin_hi_s;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic [6:0] own_addr;
  logic [7:0] byte_in;
  logic [7:0] sel_code;

  // Bus pins and straps are asynchronous to clk
  pin_sync #(.RESET_VAL(1'b1)) u_sync_scl (.clk(clk), .rst_n(rst_n), .pin_in(scl_in), .pin_out(scl_s));
  pin_sync #(.RESET_VAL(1'b1)) u_sync_sda (.clk(clk), .rst_n(rst_n), .pin_in(sda_in), .pin_out(sda_s));
  pin_sync #(.RESET_VAL(1'b0)) u_sync_lo (.clk(clk), .rst_n(rst_n), .pin_in(addr_pin_low), .pin_out(pin_lo_s));
  pin_sync #(.RESET_VAL(1'b0)) u_sync_hi (.clk(clk), .rst_n(rst_n), .pin_in(addr_pin_high), .pin_out(pin_hi_s));

  assign scl_rise = scl_s && !st_r.scl_d;
  assign scl_fall = !scl_s && st_r.scl_d;
  // Data edges while clock high mark frame bounds
  assign start_det = st_r.scl_d && scl_s && st_r.sda_d && !sda_s; // see RL1
  assign stop_det = st_r.scl_d && scl_s && !st_r.sda_d && sda_s; // see RL16

  // Straps re-read only while the bus is idle
  assign own_addr = USE_ADDR_PINS ? {DEV_ADDR[6:2], st_r.pins} : DEV_ADDR; // see RL23
  assign byte_in = {st_r.shreg[6:0], sda_s};
  assign sel_code = st_r.chsel ? st_r.wiper2 : st_r.wiper1; // see RL14

  always_comb begin
    st_nxt = st_r;
    st_nxt.scl_d = scl_s;
    st_nxt.sda_d = sda_s;
    // Frozen during a transfer so the match cannot flip
    if (st_r.phase == ST_IDLE) begin
      st_nxt.pins = {pin_hi_s, pin_lo_s};
    end
    if (start_det) begin
      // Repeated start also restarts address phase
      st_nxt.phase = ST_ADDR;
      st_nxt.bit_cnt = wiper_pkg::BIT_ZERO;
      st_nxt.in_ack = 1'b0;
      st_nxt.ack_drv = 1'b0;
      st_nxt.tx_drv = 1'b0;
      st_nxt.ack_due = 1'b0;
      // The clock fall that closes the start is not a bit
      st_nxt.wait_rise = 1'b1;
    end else if (stop_det) begin
      st_nxt.phase = ST_IDLE;
      st_nxt.ack_due = 1'b0;
      st_nxt.ack_drv = 1'b0;
      st_nxt.tx_drv = 1'b0;
      st_nxt.in_ack = 1'b0;
    end else if (st_r.phase != ST_IDLE && st_r.phase != ST_IGNORE) begin
      if (scl_rise) begin
        // Sample on rising clock edge only
        st_nxt.wait_rise = 1'b0;
        if (st_r.in_ack) begin
          if (st_r.phase == ST_RDATA) begin
            st_nxt.rd_nack = sda_s; // see RL18
          end
        end else begin
          st_nxt.shreg = byte_in;
          if (st_r.bit_cnt == wiper_pkg::BIT_LAST) begin
            case (st_r.phase)
              ST_ADDR: begin
                if (byte_in[7:1] == own_addr) begin // see RL2
                  st_nxt.ack_due = 1'b1; // see RL3
                  st_nxt.phase = byte_in[0] ? ST_RDATA : ST_INSTR; // see RL5
                  st_nxt.tx = sel_code; // see RL13
                end else begin
                  st_nxt.phase = ST_IGNORE; // see RL4
                end
              end
              ST_INSTR: begin
                st_nxt.chsel = byte_in[wiper_pkg::INSTR_CHAN_BIT]; // see RL6, RL15
                st_nxt.shdn = byte_in[wiper_pkg::INSTR_SHDN_BIT]; // see RL7, RL10
                st_nxt.ack_due = 1'b1;
                st_nxt.phase = ST_WDATA;
              end
              ST_WDATA: begin
                // Stored even in shutdown; ladder follows on release
                if (st_r.chsel) begin // see RL9, RL19
                  st_nxt.wiper2 = byte_in;
                end else begin
                  st_nxt.wiper1 = byte_in;
                end
                st_nxt.ack_due = 1'b1; // see RL11
              end
              default: begin
              end
            endcase
          end
        end
      end else if (scl_fall && !st_r.wait_rise) begin
        // Drive changes only after falling clock edge
        if (st_r.in_ack) begin // see RL12
          st_nxt.in_ack = 1'b0;
          st_nxt.ack_drv = 1'b0;
          st_nxt.bit_cnt = wiper_pkg::BIT_ZERO;
          if (st_r.phase == ST_RDATA) begin
            if (st_r.rd_nack) begin
              st_nxt.phase = ST_IGNORE; // see RL18
              st_nxt.tx_drv = 1'b0;
            end else begin
              st_nxt.tx = sel_code; // see RL21
              st_nxt.tx_drv = 1'b1;
            end
          end
        end else if (st_r.bit_cnt == wiper_pkg::BIT_LAST) begin
          st_nxt.in_ack = 1'b1;
          st_nxt.bit_cnt = wiper_pkg::BIT_ACK;
          // Pulling low while the clock is high would look like a start
          st_nxt.ack_drv = st_r.ack_due; // see RL3, RL12
          st_nxt.ack_due = 1'b0;
          if (st_r.phase == ST_RDATA && st_r.tx_drv) begin
            st_nxt.tx_drv = 1'b0;
          end else if (st_r.phase == ST_RDATA) begin
            // Address byte just received: acknowledge slot comes before first data bit
            st_nxt.in_ack = 1'b1;
          end
        end else begin
          st_nxt.bit_cnt = st_r.bit_cnt + 4'h1;
          if (st_r.tx_drv) begin
            st_nxt.tx = {st_r.tx[6:0], 1'b0};
          end
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
      st_r.phase <= ST_IDLE;
      st_r.scl_d <= 1'b1;
      st_r.sda_d <= 1'b1;
      st_r.wiper1 <= wiper_pkg::WIPER_MIDSCALE; // see RL22
      st_r.wiper2 <= wiper_pkg::WIPER_MIDSCALE; // see RL22
    end else begin
      st_r <= st_nxt; // see RL24
    end
  end

  // Open-drain: only ever pull low
  assign sda_out = 1'b0;
  assign sda_oe_n = !(st_r.ack_drv || (st_r.tx_drv && !st_r.tx[7]));
  assign wiper_register_1 = st_r.wiper1;
  assign wiper_register_2 = st_r.wiper2;
  // Shutdown shorts wiper to B; stored codes untouched
  assign ladder_code_1 = st_r.shdn ? 8'h00 : st_r.wiper1; // see RL8
  assign ladder_code_2 = st_r.shdn ? 8'h00 : st_r.wiper2; // see RL8
  assign shutdown_bit = st_r.shdn;
  assign channel_select_bit = st_r.chsel;

  // Byte and acknowledge boundaries used by the checks
  logic chk_byte_end;
  logic chk_ack_end;
  assign chk_byte_end = scl_rise && !st_r.in_ack && st_r.bit_cnt == wiper_pkg::BIT_LAST && !start_det && !stop_det;
  assign chk_ack_end = scl_fall && !st_r.wait_rise && st_r.in_ack && !start_det && !stop_det;

  // Address phase
  AST_ACK_AFTER_MATCH: assert property (@(posedge clk) disable iff (!rst_n) // see RL3
    st_r.phase == ST_ADDR && chk_byte_end && byte_in[7:1] == own_addr
    |=> st_r.ack_due)
    else $error("address match not acknowledged");
  AST_MISMATCH_IGNORED: assert property (@(posedge clk) disable iff (!rst_n) // see RL4
    st_r.phase == ST_ADDR && chk_byte_end && byte_in[7:1] != own_addr
    |=> st_r.phase == ST_IGNORE && !st_r.ack_due)
    else $error("foreign address not ignored");
  AST_WRITE_GOES_INSTR: assert property (@(posedge clk) disable iff (!rst_n) // see RL5
    st_r.phase == ST_ADDR && chk_byte_end && byte_in[7:1] == own_addr && !byte_in[0]
    |=> st_r.phase == ST_INSTR)
    else $error("write address did not lead to instruction");
  AST_READ_LOADS: assert property (@(posedge clk) disable iff (!rst_n) // see RL13
    st_r.phase == ST_ADDR && chk_byte_end && byte_in[7:1] == own_addr && byte_in[0]
    |=> st_r.phase == ST_RDATA && st_r.tx == $past(sel_code))
    else $error("read code not loaded at address");
  AST_START_RESTARTS: assert property (@(posedge clk) disable iff (!rst_n) // see RL1
    start_det
    |=> st_r.phase == ST_ADDR && st_r.bit_cnt == wiper_pkg::BIT_ZERO && !st_r.ack_drv && !st_r.tx_drv)
    else $error("start did not restart address phase");

  // Line driving and bit counter range
  AST_IGNORE_RELEASED: assert property (@(posedge clk) disable iff (!rst_n) // see RL4
    st_r.phase == ST_IGNORE
    |-> sda_oe_n)
    else $error("sda driven while ignoring");
  AST_IDLE_RELEASED: assert property (@(posedge clk) disable iff (!rst_n) // see RL4
    st_r.phase == ST_IDLE
    |-> sda_oe_n)
    else $error("sda driven while idle");
  AST_NO_CHANGE_CLK_HIGH: assert property (@(posedge clk) disable iff (!rst_n) // see RL12
    (st_r.scl_d && scl_s && !$past(scl_fall))
    |=> $stable(sda_oe_n) || st_r.phase == ST_IDLE
      || $past(start_det) || $past(stop_det))
    else $error("sda changed while clock high");
  AST_SDA_MOVES_ON_LOW: assert property (@(posedge clk) disable iff (!rst_n) // see RL12
    $changed(sda_oe_n)
    |-> $past(scl_fall) || $past(start_det) || $past(stop_det))
    else $error("sda moved without a clock fall");
  AST_ACK_ON_CLK_LOW: assert property (@(posedge clk) disable iff (!rst_n) // see RL3
    $rose(st_r.ack_drv)
    |-> $past(scl_fall))
    else $error("acknowledge raised outside clock low");
  AST_BIT_CNT_RANGE: assert property (@(posedge clk) disable iff (!rst_n) // see RL11
    st_r.phase != ST_IDLE
    |-> st_r.bit_cnt <= wiper_pkg::BIT_ACK)
    else $error("bit counter past acknowledge slot");

  // Instruction and data
  AST_INSTR_LATCH: assert property (@(posedge clk) disable iff (!rst_n) // see RL6
    st_r.phase == ST_INSTR && chk_byte_end
    |=> st_r.chsel == $past(byte_in[wiper_pkg::INSTR_CHAN_BIT]) && st_r.phase == ST_WDATA && st_r.ack_due)
    else $error("channel select not latched");
  AST_SHDN_LATCH: assert property (@(posedge clk) disable iff (!rst_n) // see RL7
    st_r.phase == ST_INSTR && chk_byte_end
    |=> st_r.shdn == $past(byte_in[wiper_pkg::INSTR_SHDN_BIT]))
    else $error("shutdown bit not latched");
  AST_WRITE_CH1: assert property (@(posedge clk) disable iff (!rst_n) // see RL19
    st_r.phase == ST_WDATA && chk_byte_end && !st_r.chsel
    |=> st_r.wiper1 == $past(byte_in) && $stable(st_r.wiper2) && st_r.ack_due)
    else $error("first channel code not stored");
  AST_WRITE_CH2: assert property (@(posedge clk) disable iff (!rst_n) // see RL9
    st_r.phase == ST_WDATA && chk_byte_end && st_r.chsel
    |=> st_r.wiper2 == $past(byte_in) && $stable(st_r.wiper1) && st_r.ack_due)
    else $error("second channel code not stored");
  AST_WIPER_ONLY_WDATA: assert property (@(posedge clk) disable iff (!rst_n) // see RL24
    st_r.phase != ST_WDATA
    |=> $stable(st_r.wiper1) && $stable(st_r.wiper2))
    else $error("wiper written outside data phase");

  // Shutdown and ladder
  AST_SHDN_KEEPS: assert property (@(posedge clk) disable iff (!rst_n) // see RL8
    $rose(st_r.shdn)
    |-> $stable(st_r.wiper1) && $stable(st_r.wiper2))
    else $error("shutdown changed stored code");
  AST_LADDER_FOLLOWS: assert property (@(posedge clk) disable iff (!rst_n) // see RL8
    !st_r.shdn
    |-> ladder_code_1 == st_r.wiper1 && ladder_code_2 == st_r.wiper2)
    else $error("ladder not showing stored code");
  AST_LADDER_SHDN: assert property (@(posedge clk) disable iff (!rst_n) // see RL7
    st_r.shdn
    |-> ladder_code_1 == 8'h00 && ladder_code_2 == 8'h00)
    else $error("ladder not at terminal B in shutdown");

  // Read and end of transfer
  AST_READ_REPEAT: assert property (@(posedge clk) disable iff (!rst_n) // see RL21
    st_r.phase == ST_RDATA && chk_ack_end && !st_r.rd_nack
    |=> st_r.tx_drv && st_r.tx == $past(sel_code))
    else $error("read code not resent after acknowledge");
  AST_NACK_ENDS: assert property (@(posedge clk) disable iff (!rst_n) // see RL18
    st_r.phase == ST_RDATA && chk_ack_end && st_r.rd_nack
    |=> st_r.phase == ST_IGNORE && !st_r.tx_drv)
    else $error("not-acknowledge did not end read");
  AST_STOP_IDLES: assert property (@(posedge clk) disable iff (!rst_n) // see RL16
    stop_det && !start_det
    |=> st_r.phase == ST_IDLE ##1 sda_oe_n)
    else $error("stop did not end transfer");

  COV_WRITE: cover property (@(posedge clk) disable iff (!rst_n)
    st_r.phase == ST_WDATA && $changed(st_r.wiper2));
  COV_READ: cover property (@(posedge clk) disable iff (!rst_n)
    st_r.phase == ST_RDATA && $rose(st_r.tx_drv));
  COV_SHDN: cover property (@(posedge clk) disable iff (!rst_n) $fell(st_r.shdn));
  COV_NACK: cover property (@(posedge clk) disable iff (!rst_n)
    st_r.phase == ST_RDATA && chk_ack_end && st_r.rd_nack);
  COV_MISMATCH: cover property (@(posedge clk) disable iff (!rst_n)
    st_r.phase == ST_ADDR && chk_byte_end && byte_in[7:1] != own_addr);
endmodule : dual_wiper_i2c_target

// ---- dual_wiper_i2c_target_tb_top.sv ----
// Self-checking bench for the dual wiper two-wire target
`timescale 1ns/100ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin err_total++; $display("Error t=%0t got %h exp %h", $time, (a), (b)); end end
module dual_wiper_i2c_target_tb_top;
  localparam logic [6:0] ADDR = {wiper_pkg::DEV_ADDR_DEFAULT[6:2], 2'h1};
  logic clk;
  logic rst_n;
  logic scl;
  logic sda_rel;
  logic sda;
  logic sda_out;
  logic sda_oe_n;
  logic pin_lo;
  logic pin_hi;
  logic [7:0] w1;
  logic [7:0] w2;
  logic [7:0] l1;
  logic [7:0] l2;
  logic shdn;
  logic sel;
  logic [7:0] rx;
  logic ack;
  int err_total = 0;
  int cmp_count = 0;
  int cyc = 0;
  // Pull-up: line is low only when some party pulls it
  assign sda = sda_rel & (sda_oe_n | sda_out);
  bus_ctl_model u_ctl (
    .clk(clk),
    .sda(sda),
    .scl(scl),
    .sda_rel(sda_rel)
  );
  dual_wiper_i2c_target u_dut (
    .clk(clk),
    .rst_n(rst_n),
    .scl_in(scl),
    .sda_in(sda),
    .sda_out(sda_out),
    .sda_oe_n(sda_oe_n),
    .addr_pin_low(pin_lo),
    .addr_pin_high(pin_hi),
    .wiper_register_1(w1),
    .wiper_register_2(w2),
    .ladder_code_1(l1),
    .ladder_code_2(l2),
    .shutdown_bit(shdn),
    .channel_select_bit(sel)
  );
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic complete_run();
    if (err_total == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : complete_run
  // Hang guard, runs far longer than the whole sequence
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      complete_run();
    end
  end
  task automatic send(input logic [7:0] b, input logic exp_ack);
    u_ctl.xfer(b, 1'b1, rx, ack);
    `CHK(ack, exp_ack)
  endtask : send
  task automatic recv(input logic last, input logic [7:0] exp);
    u_ctl.xfer(8'hFF, last, rx, ack);
    `CHK(rx, exp)
  endtask : recv
  initial begin
    rst_n = 1'b0;
    pin_lo = 1'b1;
    pin_hi = 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (8) @(posedge clk);
    `CHK({w1, w2, shdn, sel, sda_oe_n}, {16'h8080, 3'h1})
    u_ctl.start();
    send({ADDR, 1'b0}, 1'b0);
    send(8'h3F, 1'b0);
    send(8'h5A, 1'b0);
    `CHK(w1, 8'h5A)
    send(8'hC3, 1'b0);
    u_ctl.stop();
    `CHK({w1, w2, sel, shdn}, {16'hC380, 2'h0})
    u_ctl.start();
    send({ADDR, 1'b0}, 1'b0);
    send(8'hC0, 1'b0);
    send(8'h11, 1'b0);
    u_ctl.stop();
    `CHK({w1, w2, l1, l2, sel, shdn}, {32'hC3110000, 2'h3})
    u_ctl.start();
    send({ADDR, 1'b1}, 1'b0);
    recv(1'b0, 8'h11);
    recv(1'b1, 8'h11);
    u_ctl.stop();
    // Instruction alone, then repeated start into a read
    u_ctl.start();
    send({ADDR, 1'b0}, 1'b0);
    send(8'h00, 1'b0);
    u_ctl.start();
    send({ADDR, 1'b1}, 1'b0);
    recv(1'b1, 8'hC3);
    u_ctl.stop();
    `CHK({l1, l2, sel, shdn}, {16'hC311, 2'h0})
    u_ctl.start();
    send({ADDR ^ 7'h01, 1'b0}, 1'b1);
    send(8'h80, 1'b1);
    send(8'h77, 1'b1);
    u_ctl.stop();
    `CHK({w1, w2, sel, shdn, sda_oe_n}, {16'hC311, 3'h1})
    complete_run();
  end
endmodule : dual_wiper_i2c_target_tb_top

// ---- pin_sync.sv ----
// Two-stage synchroniser for one pin
`timescale 1ns/100ps
module pin_sync #(
  parameter logic RESET_VAL = 1'b1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Pin and synchronised level
  input wire logic pin_in,
  output logic pin_out
);
  typedef struct packed {
    logic s1;
    logic s2;
  } sync_state_t;

  sync_state_t st_r;
  sync_state_t st_nxt;

  always_comb begin
    st_nxt.s1 = pin_in;
    st_nxt.s2 = st_r.s1;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= {RESET_VAL, RESET_VAL};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign pin_out = st_r.s2;
endmodule : pin_sync

// ---- wiper_pkg.sv ----
// Constants shared by the dual wiper two-wire target
package wiper_pkg;
  localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h2F;
  localparam logic [7:0] WIPER_MIDSCALE = 8'h80;
  localparam int INSTR_CHAN_BIT = 7;
  localparam int INSTR_SHDN_BIT = 6;
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] BIT_ACK = 4'h8;
  localparam logic [3:0] BIT_ZERO = 4'h0;
  localparam int SYNC_STAGES = 2;
endpackage : wiper_pkg
